//--- verilog/wncr_consts.vh
`ifndef WNCR_CONSTS_VH
`define WNCR_CONSTS_VH
// Record word offsets within a node slot
`define WNCR_OFS_CHAN_HI 6'h11
`define WNCR_OFS_CHAN_LO 6'h12
`define WNCR_OFS_LINK_SLEEP 6'h13
`define WNCR_OFS_STD_IVL 6'h14
`define WNCR_OFS_EXC_IVL 6'h15
`define WNCR_OFS_RETRY 6'h16
`define WNCR_OFS_FAIL_LIM 6'h17
`define WNCR_OFS_PROFILE 6'h18
`define WNCR_OFS_SAMPLES 6'h19
`define WNCR_OFS_HYST_HI 6'h1a
`define WNCR_OFS_HYST_LO 6'h1b
`define WNCR_OFS_LOTH_HI 6'h1c
`define WNCR_OFS_LOTH_LO 6'h1d
`define WNCR_OFS_UPTH_HI 6'h1e
`define WNCR_OFS_UPTH_LO 6'h1f
// Slot layout
`define WNCR_SLOT_WORDS 16'h0032
`define WNCR_RAW_BASE 16'h07d0
// Link sleep decode
`define WNCR_SLEEP_HOUR_MAX 16'h0012
`define WNCR_SLEEP_MIN_BASE 16'h0064
`define WNCR_SLEEP_DEF_HOURS 16'h0002
// Field limits
`define WNCR_RETRY_MAX 16'h000a
`define WNCR_SAMPLES_MAX 16'h00fa
// Profile codes
`define WNCR_PROFILE_INTERVAL 16'h0001
`define WNCR_PROFILE_TRIGGER 16'h0002
// Reset values
`define WNCR_RST_ZERO 16'h0000
`define WNCR_RST_SAMPLES 16'h0001
// Timing
`define WNCR_CLK_HZ 40000000
`define WNCR_SECS_PER_MIN 16'h003c
`define WNCR_MINS_PER_HOUR 16'h003c
`endif

//--- verilog/wncr_record.v
`timescale 1ns/100ps
`default_nettype none
`include "wncr_consts.vh"

module wncr_record #(
   parameter [7:0] SLOT = 8'h00,
   parameter [1:0] PROFILE_KIND = 2'h1,
   parameter integer CLK_HZ = `WNCR_CLK_HZ
) (
   input wire core_clk,
   input wire reset_n,
   // Word access from the serial slave, raw register address
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire [15:0] reg_wdata,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg reg_hit,
   // Node behaviour inputs
   input wire link_lost,
   input wire gw_found,
   input wire scan_done,
   input wire report_done,
   input wire report_ok,
   input wire event_seen,
   input wire [31:0] observed,
   // Node behaviour outputs
   output reg [31:0] permitted_channel_bits,
   output reg scan_active,
   output reg link_sleeping,
   output reg report_req,
   output reg attempt_retry,
   output reg sample_strobe,
   output reg exception_active,
   output reg relink_req
);

////////////////////////////////////////////////////////////////////////////////
localparam [15:0] SLOT_BASE = `WNCR_RAW_BASE + `WNCR_SLOT_WORDS * {8'h00, SLOT};
localparam integer SEC_CYC = CLK_HZ;

// Every flop except the two sync flops leaves reset on the same edge, two edges after the pin rises
reg rst_meta_r;
reg rst_sync_r;
always @(posedge core_clk or negedge reset_n) begin
   if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
   end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
   end
end
wire rst_n = rst_sync_r;

////////////////////////////////////////////////////////////////////////////////
// One-second tick shared by all timers
// CLK_HZ may be lowered for simulation; every second then shrinks with it
reg [31:0] tick_cnt_r;
reg sec_tick_r;
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      tick_cnt_r <= 32'h00000000;
      sec_tick_r <= 1'b0;
   end else if (tick_cnt_r == SEC_CYC - 1) begin
      tick_cnt_r <= 32'h00000000;
      sec_tick_r <= 1'b1;
   end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      sec_tick_r <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Register file
// One register per writable record word
reg [15:0] chan_hi_r;
reg [15:0] chan_lo_r;
reg [15:0] sleep_r;
reg [15:0] std_ivl_r;
reg [15:0] exc_ivl_r;
reg [15:0] retry_r;
reg [15:0] fail_lim_r;
reg [15:0] samples_r;
reg [15:0] hyst_hi_r;
reg [15:0] hyst_lo_r;
reg [15:0] loth_hi_r;
reg [15:0] loth_lo_r;
reg [15:0] upth_hi_r;
reg [15:0] upth_lo_r;
// Writes outside the slot or to the fixed profile word are dropped silently
wire [15:0] rel = reg_addr - SLOT_BASE;
wire in_slot = (reg_addr >= SLOT_BASE) && (rel < `WNCR_SLOT_WORDS);
wire [5:0] ofs = rel[5:0];
wire [15:0] profile_word = {14'h0000, PROFILE_KIND};

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      chan_hi_r <= `WNCR_RST_ZERO;
      chan_lo_r <= `WNCR_RST_ZERO;
      sleep_r <= `WNCR_RST_ZERO;
      std_ivl_r <= `WNCR_RST_ZERO;
      exc_ivl_r <= `WNCR_RST_ZERO;
      retry_r <= `WNCR_RST_ZERO;
      fail_lim_r <= `WNCR_RST_ZERO;
      samples_r <= `WNCR_RST_SAMPLES;
      hyst_hi_r <= `WNCR_RST_ZERO;
      hyst_lo_r <= `WNCR_RST_ZERO;
      loth_hi_r <= `WNCR_RST_ZERO;
      loth_lo_r <= `WNCR_RST_ZERO;
      upth_hi_r <= `WNCR_RST_ZERO;
      upth_lo_r <= `WNCR_RST_ZERO;
   end else if (reg_wr && in_slot) begin
      case (ofs)
         `WNCR_OFS_CHAN_HI: chan_hi_r <= reg_wdata;
         `WNCR_OFS_CHAN_LO: chan_lo_r <= reg_wdata;
         `WNCR_OFS_LINK_SLEEP: sleep_r <= reg_wdata;
         `WNCR_OFS_STD_IVL: std_ivl_r <= reg_wdata;
         `WNCR_OFS_EXC_IVL: exc_ivl_r <= reg_wdata;
         `WNCR_OFS_RETRY: retry_r <= reg_wdata;
         `WNCR_OFS_FAIL_LIM: fail_lim_r <= reg_wdata;
         `WNCR_OFS_SAMPLES: samples_r <= reg_wdata;
         `WNCR_OFS_HYST_HI: hyst_hi_r <= reg_wdata;
         `WNCR_OFS_HYST_LO: hyst_lo_r <= reg_wdata;
         `WNCR_OFS_LOTH_HI: loth_hi_r <= reg_wdata;
         `WNCR_OFS_LOTH_LO: loth_lo_r <= reg_wdata;
         `WNCR_OFS_UPTH_HI: upth_hi_r <= reg_wdata;
         `WNCR_OFS_UPTH_LO: upth_lo_r <= reg_wdata;
         // Profile word and every other offset drop the write
         default: ;
      endcase
   end
end

// Profile is fixed by the build, never by the bus
reg [15:0] rd_nxt;
always @* begin
   case (ofs)
      `WNCR_OFS_CHAN_HI: rd_nxt = chan_hi_r;
      `WNCR_OFS_CHAN_LO: rd_nxt = chan_lo_r;
      `WNCR_OFS_LINK_SLEEP: rd_nxt = sleep_r;
      `WNCR_OFS_STD_IVL: rd_nxt = std_ivl_r;
      `WNCR_OFS_EXC_IVL: rd_nxt = exc_ivl_r;
      `WNCR_OFS_RETRY: rd_nxt = retry_r;
      `WNCR_OFS_FAIL_LIM: rd_nxt = fail_lim_r;
      `WNCR_OFS_PROFILE: rd_nxt = profile_word;
      `WNCR_OFS_SAMPLES: rd_nxt = samples_r;
      `WNCR_OFS_HYST_HI: rd_nxt = hyst_hi_r;
      `WNCR_OFS_HYST_LO: rd_nxt = hyst_lo_r;
      `WNCR_OFS_LOTH_HI: rd_nxt = loth_hi_r;
      `WNCR_OFS_LOTH_LO: rd_nxt = loth_lo_r;
      `WNCR_OFS_UPTH_HI: rd_nxt = upth_hi_r;
      `WNCR_OFS_UPTH_LO: rd_nxt = upth_lo_r;
      default: rd_nxt = `WNCR_RST_ZERO;
   endcase
end

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
      permitted_channel_bits <= 32'h00000000;
   end else begin
      reg_hit <= (reg_rd | reg_wr) & in_slot;
      // Read data holds until the next read of this slot; misses leave it alone
      if (reg_rd && in_slot) begin
         reg_rdata <= rd_nxt;
      end
      permitted_channel_bits <= {chan_hi_r, chan_lo_r};
   end
end

wire [31:0] hyst = {hyst_hi_r, hyst_lo_r};
wire [31:0] lo_lim = {loth_hi_r, loth_lo_r};
wire [31:0] up_lim = {upth_hi_r, upth_lo_r};

////////////////////////////////////////////////////////////////////////////////
// Link sleep decode into seconds
reg [31:0] sleep_secs;
always @* begin
   if (sleep_r >= 16'h0001 && sleep_r <= `WNCR_SLEEP_HOUR_MAX) begin
      sleep_secs = {16'h0000, sleep_r} * `WNCR_MINS_PER_HOUR * `WNCR_SECS_PER_MIN;
   end else if (sleep_r > `WNCR_SLEEP_MIN_BASE) begin
      sleep_secs = {16'h0000, sleep_r - `WNCR_SLEEP_MIN_BASE} * `WNCR_SECS_PER_MIN;
   end else begin
      // Values 19 to 100 land here as well as zero
      sleep_secs = {16'h0000, `WNCR_SLEEP_DEF_HOURS} * `WNCR_MINS_PER_HOUR
                   * `WNCR_SECS_PER_MIN;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Link state machine
// Idle until the first loss of network; a fresh node waits for the radio side
localparam [3:0] LS_SCAN = 4'h1;
localparam [3:0] LS_SLEEP = 4'h2;
localparam [3:0] LS_UP = 4'h4;
localparam [3:0] LS_IDLE = 4'h8;
reg [3:0] ls_r;
reg [31:0] sleep_cnt_r;
reg [3:0] fail_cnt_r;
reg [3:0] try_cnt_r;
reg [15:0] ivl_cnt_r;
reg [7:0] samp_cnt_r;
reg exc_r;
reg report_busy_r;
// Limits are absolute levels, so a lower limit of zero never fires
wire exc_raise = (observed < lo_lim) || (observed > up_lim);
// Clear only once back inside both limits by at least the hysteresis
wire exc_clear = ({1'b0, observed} >= {1'b0, lo_lim} + {1'b0, hyst}) &&
                 ({1'b0, observed} + {1'b0, hyst} <= {1'b0, up_lim});
wire is_trigger = (profile_word == `WNCR_PROFILE_TRIGGER);
wire [15:0] ivl_len = exc_r ? exc_ivl_r : std_ivl_r;
wire ivl_due = sec_tick_r && (ivl_cnt_r + 16'h0001 >= ivl_len);
wire fail_relink = (fail_lim_r != 16'h0000) &&
                   ({12'h000, fail_cnt_r} + 16'h0001 >= fail_lim_r);
// An out-of-range retry limit gives no retries at all
wire retry_left = ({12'h000, try_cnt_r} < retry_r) && (retry_r <= `WNCR_RETRY_MAX);

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      ls_r <= LS_IDLE;
      sleep_cnt_r <= 32'h00000000;
      fail_cnt_r <= 4'h0;
      try_cnt_r <= 4'h0;
      ivl_cnt_r <= 16'h0000;
      exc_r <= 1'b0;
      report_busy_r <= 1'b0;
      scan_active <= 1'b0;
      link_sleeping <= 1'b0;
      report_req <= 1'b0;
      attempt_retry <= 1'b0;
      sample_strobe <= 1'b0;
      exception_active <= 1'b0;
      relink_req <= 1'b0;
   end else begin
      report_req <= 1'b0;
      attempt_retry <= 1'b0;
      sample_strobe <= 1'b0;
      relink_req <= 1'b0;
      case (ls_r)
         LS_IDLE: begin
            if (link_lost) begin
               ls_r <= LS_SCAN;
            end
         end
         LS_SCAN: begin
            // A found gateway wins over an end of scan in the same cycle
            if (gw_found) begin
               ls_r <= LS_UP;
               fail_cnt_r <= 4'h0;
               ivl_cnt_r <= 16'h0000;
            end else if (scan_done) begin
               ls_r <= LS_SLEEP;
               sleep_cnt_r <= 32'h00000000;
            end
         end
         LS_SLEEP: begin
            // Counted in whole ticks, so the sleep may end up to one tick early
            if (sec_tick_r) begin
               if (sleep_cnt_r + 32'h00000001 >= sleep_secs) begin
                  ls_r <= LS_SCAN;
               end else begin
                  sleep_cnt_r <= sleep_cnt_r + 32'h00000001;
               end
            end
         end
         LS_UP: begin
            if (link_lost) begin
               ls_r <= LS_SCAN;
               report_busy_r <= 1'b0;
            end else begin
               // Sampling and exception tracking at one-second granularity
               // Trigger nodes skip the tick; events and the interval drive them
               if (sec_tick_r && !is_trigger) begin
                  sample_strobe <= 1'b1;
                  if (!exc_r && exc_raise) begin
                     exc_r <= 1'b1;
                     if (!report_busy_r) begin
                        report_req <= 1'b1;
                        report_busy_r <= 1'b1;
                        try_cnt_r <= 4'h0;
                        ivl_cnt_r <= 16'h0000;
                     end
                  end else if (exc_r && exc_clear) begin
                     exc_r <= 1'b0;
                  end
               end
               if (!report_busy_r && (ivl_due || (is_trigger && event_seen))) begin
                  report_req <= 1'b1;
                  report_busy_r <= 1'b1;
                  try_cnt_r <= 4'h0;
                  ivl_cnt_r <= 16'h0000;
               end else if (sec_tick_r && !(sec_tick_r && !is_trigger && !exc_r && exc_raise)) begin
                  ivl_cnt_r <= ivl_due ? 16'h0000 : ivl_cnt_r + 16'h0001;
               end
               if (report_busy_r && report_done) begin
                  if (report_ok) begin
                     report_busy_r <= 1'b0;
                     fail_cnt_r <= 4'h0;
                  // Retry until the limit, then count one failed report
                  end else if (retry_left) begin
                     attempt_retry <= 1'b1;
                     try_cnt_r <= try_cnt_r + 4'h1;
                  end else begin
                     report_busy_r <= 1'b0;
                     if (fail_relink) begin
                        relink_req <= 1'b1;
                        ls_r <= LS_SCAN;
                        fail_cnt_r <= 4'h0;
                     end else if (fail_cnt_r != 4'hf) begin
                        fail_cnt_r <= fail_cnt_r + 4'h1;
                     end
                  end
               end
            end
         end
         default: ls_r <= LS_IDLE;
      endcase
      scan_active <= (ls_r == LS_SCAN);
      link_sleeping <= (ls_r == LS_SLEEP);
      exception_active <= exc_r;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Samples per report; kept apart from the link machine so that a new sample
// count never disturbs report timing
wire sample_due = (ls_r == LS_UP) && !link_lost && sec_tick_r && !is_trigger;
wire samp_last = ({8'h00, samp_cnt_r} + 16'h0001 >= samples_r);

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      samp_cnt_r <= 8'h00;
   end else if (sample_due) begin
      if (samp_last) begin
         samp_cnt_r <= 8'h00;
      end else begin
         samp_cnt_r <= samp_cnt_r + 8'h01;
      end
   end
end

endmodule // wncr_record
`default_nettype wire

//--- verification/wncr_record_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module wncr_record_monitor #(
   parameter [7:0] SLOT = 8'h00,
   parameter [1:0] PROFILE_KIND = 2'h1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic [31:0] permitted_channel_bits,
   input wire logic scan_active,
   input wire logic link_sleeping,
   input wire logic relink_req
);
   logic [15:0] ofs;
   logic in_slot;
   logic rd_hit;
   // Wraps below the slot base, so one compare covers both ends
   assign ofs = reg_addr - (16'h07d0 + 16'h0032 * SLOT);
   assign in_slot = ofs < 16'h0032;
   assign rd_hit = reg_rd && in_slot;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_hit; rd_hit |=> reg_hit; endproperty
   a_hit: assert property (p_hit) else $error("slot read gave no hit");
   property p_miss; !((reg_rd || reg_wr) && in_slot) |=> !reg_hit; endproperty
   a_miss: assert property (p_miss) else $error("hit without slot access");
   property p_prof; rd_hit && ofs == 16'h0018 |=> reg_rdata == {14'h0000, PROFILE_KIND}; endproperty
   a_prof: assert property (p_prof) else $error("profile word wrong");
   property p_unused; rd_hit && (ofs < 16'h0011 || ofs > 16'h001f) |=> reg_rdata == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused word not zero");
   property p_chan_hi; reg_wr && in_slot && ofs == 16'h0011
      |=> ##1 permitted_channel_bits[31:16] == $past(reg_wdata, 2); endproperty
   a_chan_hi: assert property (p_chan_hi) else $error("mask high word wrong");
   property p_chan_lo; reg_wr && in_slot && ofs == 16'h0012
      |=> ##1 permitted_channel_bits[15:0] == $past(reg_wdata, 2); endproperty
   a_chan_lo: assert property (p_chan_lo) else $error("mask low word wrong");
   property p_hold; !rd_hit |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_sleep; link_sleeping |-> !scan_active; endproperty
   a_sleep: assert property (p_sleep) else $error("scanning while asleep");
   property p_relink; relink_req |-> ##[0:3] scan_active; endproperty
   a_relink: assert property (p_relink) else $error("relink without rescan");
endmodule // wncr_record_monitor
bind wncr_record wncr_record_monitor #(.SLOT(SLOT), .PROFILE_KIND(PROFILE_KIND)) mon_u (
   .core_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit,
   .permitted_channel_bits, .scan_active, .link_sleeping, .relink_req);
`default_nettype wire

//--- verification/wncr_master.sv
`timescale 1ns/100ps
`default_nettype none
module wncr_master #(
   parameter [7:0] SLOT = 8'h00
) (
   input wire logic core_clk,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_hit
);
   localparam logic [15:0] BASE = 16'h07d0 + 16'h0032 * SLOT;
   initial begin
      reg_addr = 16'hffff;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
   end
   // Released lines flip, so stale values never look like a live access
   task automatic wr(input logic [15:0] ofs, input logic [15:0] data);
      @(negedge core_clk);
      reg_addr = BASE + ofs;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [15:0] ofs, output logic [15:0] data, output logic hit);
      @(negedge core_clk);
      reg_addr = BASE + ofs;
      reg_rd = 1'b1;
      @(negedge core_clk);
      data = reg_rdata;
      hit = reg_hit;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
   endtask
endmodule // wncr_master
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic core_clk = 1'b0, reset_n = 1'b0, event_seen = 1'b0, report_ok = 1'b0;
   logic link_lost = 1'b0, gw_found = 1'b0, scan_done = 1'b0, report_done = 1'b0;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, rdv, e, o;
   logic reg_wr, reg_rd, reg_hit, hit, scan_active, link_sleeping, report_req, attempt_retry;
   logic sample_strobe, exception_active, relink_req;
   logic [31:0] observed = 32'h000001f4, permitted_channel_bits;
   int err_count = 0, n_compared = 0, n;
   always #12.5 core_clk = ~core_clk;
   // A CLK_HZ of 2 makes each second two cycles, keeping hour-long sleeps inside the run
   wncr_record #(.CLK_HZ(2)) dut_u (.core_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata, .reg_hit, .link_lost, .gw_found, .scan_done, .report_done,
      .report_ok, .event_seen, .observed, .permitted_channel_bits, .scan_active,
      .link_sleeping, .report_req, .attempt_retry, .sample_strobe, .exception_active,
      .relink_req);
   wncr_master mst_u (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_cyc(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("unexpected delay at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask
   function automatic logic sel(input int i);
      logic [6:0] v;
      v = {sample_strobe, relink_req, exception_active, attempt_retry, report_req,
         link_sleeping, scan_active};
      return v[i];
   endfunction
   task automatic wait_for(input int i, input logic lvl, input int lim, output int c);
      c = 0;
      while (sel(i) !== lvl && c < lim) begin
         @(negedge core_clk);
         c++;
      end
   endtask
   task automatic pulse(input int i, input logic ok);
      @(negedge core_clk);
      {report_done, scan_done, gw_found, link_lost} = 4'h1 << i;
      report_ok = ok;
      @(negedge core_clk);
      {report_done, scan_done, gw_found, link_lost} = 4'h0;
   endtask
   task automatic cfg(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] hy);
      mst_u.wr(16'h001a, hy[31:16]);
      mst_u.wr(16'h001b, hy[15:0]);
      mst_u.wr(16'h001c, lo[31:16]);
      mst_u.wr(16'h001d, lo[15:0]);
      mst_u.wr(16'h001e, hi[31:16]);
      mst_u.wr(16'h001f, hi[15:0]);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      for (int p = 0; p < 2; p++) begin
         for (o = 16'h0010; o <= 16'h0020; o++) begin
            if (p == 1)
               mst_u.wr(o, {o[7:0], 8'ha5});
            mst_u.rd(o, rdv, hit);
            if (o == 16'h0018) e = 16'h0001;
            else if (o < 16'h0011 || o > 16'h001f) e = 16'h0000;
            else if (p == 0) e = (o == 16'h0019) ? 16'h0001 : 16'h0000;
            else e = {o[7:0], 8'ha5};
            cmp_val(hit, 1'b1);
            cmp_val(rdv, e);
         end
      end
      cmp_val(permitted_channel_bits, 32'h11a512a5);
      mst_u.wr(16'h0011, 16'h0000);
      mst_u.wr(16'h0012, 16'h0011);
      @(negedge core_clk);
      cmp_val(permitted_channel_bits, 32'h00000011);
      mst_u.rd(16'hffff, rdv, hit);
      cmp_val(hit, 1'b0);
      mst_u.rd(16'h0032, rdv, hit);
      cmp_val(hit, 1'b0);
      $display("register test done");
   endtask
   task automatic t_sleep(input logic [15:0] v, input int secs);
      mst_u.wr(16'h0013, v);
      pulse(0, 1'b0);
      wait_for(0, 1'b1, 8, n);
      cmp_val(scan_active, 1'b1);
      pulse(2, 1'b0);
      wait_for(1, 1'b1, 8, n);
      wait_for(0, 1'b1, 30000, n);
      cmp_cyc(n, 2 * secs - 4, 2 * secs + 4);
      pulse(1, 1'b0);
      wait_for(0, 1'b0, 8, n);
      cmp_val(scan_active, 1'b0);
      $display("link sleep test %0d done", v);
   endtask
   task automatic t_rep;
      mst_u.wr(16'h0014, 16'h0003);
      mst_u.wr(16'h0016, 16'h0002);
      mst_u.wr(16'h0017, 16'h0001);
      cfg(32'h00000000, 32'hffffffff, 32'h00000000);
      wait_for(6, 1'b1, 4, n);
      cmp_val(sample_strobe, 1'b1);
      pulse(3, 1'b1);
      wait_for(2, 1'b1, 20, n);
      pulse(3, 1'b1);
      wait_for(2, 1'b1, 20, n);
      cmp_cyc(n, 3, 7);
      for (int k = 0; k < 3; k++) begin
         wait_for(k == 0 ? 2 : 3, 1'b1, 20, n);
         cmp_cyc(n, 0, 19);
         pulse(3, 1'b0);
      end
      wait_for(5, 1'b1, 8, n);
      cmp_val(relink_req, 1'b1);
      pulse(1, 1'b0);
      mst_u.wr(16'h0016, 16'h0000);
      mst_u.wr(16'h0017, 16'h0000);
      wait_for(2, 1'b1, 20, n);
      pulse(3, 1'b0);
      wait_for(5, 1'b1, 30, n);
      cmp_cyc(n, 30, 30);
      $display("report test done");
   endtask
   task automatic t_exc;
      mst_u.wr(16'h0014, 16'hffff);
      cfg(32'd100, 32'd1000, 32'd50);
      pulse(3, 1'b1);
      wait_for(4, 1'b0, 20, n);
      observed = 32'd50;
      wait_for(2, 1'b1, 8, n);
      cmp_val(report_req, 1'b1);
      wait_for(4, 1'b1, 4, n);
      cmp_val(exception_active, 1'b1);
      pulse(3, 1'b1);
      observed = 32'd120;
      wait_for(4, 1'b0, 10, n);
      cmp_val(exception_active, 1'b1);
      observed = 32'd200;
      wait_for(4, 1'b0, 8, n);
      cmp_val(exception_active, 1'b0);
      observed = 32'd1100;
      wait_for(4, 1'b1, 8, n);
      cmp_val(exception_active, 1'b1);
      $display("exception test done");
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (3) @(negedge core_clk);
      t_regs;
      t_sleep(16'h0001, 3600);
      t_sleep(16'h0069, 300);
      t_sleep(16'h0032, 7200);
      t_rep;
      t_exc;
      give_verdict;
   end
   // About 25000 cycles are expected; allow well over double
   initial begin
      #1500000;
      err_count++;
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
